// >>> rtl/flash_busy_poll_ctrl.v
// busy-poll sequencer for a serial nor flash, an apb slave toward software
// and the spi single master toward the flash; one clock, one sync reset
//
// Overview of operation
// - standalone wait command confirms a write or erase has finished
// - poll limit zero: wait one poll interval of busy time, then conclude
// - nonzero limit: poll up to interval times limit, then report timeout
// - wait mode selects register-write wait or program/erase wait
// - register-write wait: repeat read-status, judge by write-in-progress flag only
// - program/erase wait: poll until ready, read security, flag fail bits
// - interval and limit are software-set per operation class
// - result is success, parameter, hardware or timeout error; no path reports other error
// - wide-address entry then read configuration; clear flag means failure
// - after initialisation is reported done, wide-address entry runs once
`timescale 1ns/10ps
`include "flash_poll_defs.vh"
module flash_busy_poll_ctrl #(
  parameter [7:0] READ_STATUS_CMD   = 8'h05,
  parameter [7:0] READ_SECURITY_CMD = 8'h2B,
  parameter [7:0] ENTER_WIDE_CMD    = 8'hB7,
  parameter [7:0] READ_CONFIG_CMD   = 8'h15,
  parameter       BUSY_BIT          = 0,
  parameter       PROG_FAIL_BIT     = 5,
  parameter       ERASE_FAIL_BIT    = 6,
  parameter       WIDE_ADDR_BIT     = 5
) (
  input  wire        CLK_SYS_IN,
  input  wire        SYS_RST_IN,
  input  wire        PSEL_IN,
  input  wire        PENABLE_IN,
  input  wire        PWRITE_IN,
  input  wire [11:0] PADDR_IN,
  input  wire [31:0] PWDATA_IN,
  output wire        PREADY_OUT,
  output reg  [31:0] PRDATA_OUT,
  output wire        PSLVERR_OUT,
  output wire        IRQ_OUT,
  output wire        SPI_SCLK_OUT,
  output reg         SPI_CS_N_OUT,
  output wire        SPI_MOSI_OUT,
  input  wire        SPI_MISO_IN
);

  // ************************************************************
  // states and frame kinds
  // ************************************************************
  localparam [2:0] S_IDLE = 3'd0;
  localparam [2:0] S_CSLO = 3'd1;
  localparam [2:0] S_CMD  = 3'd2;
  localparam [2:0] S_DATA = 3'd3;
  localparam [2:0] S_CSHI = 3'd4;
  localparam [2:0] S_WAIT = 3'd5;

  localparam [1:0] K_STATUS   = 2'd0;
  localparam [1:0] K_SECURITY = 2'd1;
  localparam [1:0] K_ENTER    = 2'd2;
  localparam [1:0] K_CONFIG   = 2'd3;

  // ************************************************************
  // declarations
  // ************************************************************
  reg  [2:0]  state_reg;
  reg  [1:0]  kind_reg;
  reg         mode_reg;
  reg  [31:0] interval_reg;
  reg  [31:0] limit_reg;
  reg  [7:0]  div_reg;
  reg  [31:0] wait_cnt_reg;
  reg  [31:0] poll_cnt_reg;
  reg  [2:0]  result_reg;
  reg         wide_ok_reg;
  reg  [7:0]  status_byte_reg;
  reg  [7:0]  sec_byte_reg;
  reg  [1:0]  irq_stat_reg;
  reg  [1:0]  irq_en_reg;
  reg         init_done_reg;
  reg         auto_done_reg;
  reg         miso_s1_reg;
  reg         miso_s2_reg;
  reg         eng_start;
  reg  [7:0]  eng_tx;
  reg         finish;
  reg  [2:0]  finish_res;
  wire        eng_done;
  wire [7:0]  eng_rx;
  wire        wr_en;
  wire        rd_en;
  wire        mapped;
  wire        busy;
  wire        sw_start;
  wire        auto_start;
  wire [31:0] eff_limit;
  wire [7:0]  half_period;

  assign busy        = (state_reg != S_IDLE);
  assign wr_en       = PSEL_IN & PENABLE_IN & PWRITE_IN;
  assign rd_en       = PSEL_IN & ~PWRITE_IN;
  assign mapped      = (PADDR_IN == `OFS_CTRL) || (PADDR_IN == `OFS_STATUS) ||
                       (PADDR_IN == `OFS_INTERVAL) || (PADDR_IN == `OFS_LIMIT) ||
                       (PADDR_IN == `OFS_IRQ_STAT) || (PADDR_IN == `OFS_IRQ_CLR) ||
                       (PADDR_IN == `OFS_IRQ_EN) || (PADDR_IN == `OFS_SCLK_DIV);
  assign PREADY_OUT  = 1'b1;
  assign PSLVERR_OUT = PSEL_IN & PENABLE_IN & ~mapped;
  assign sw_start    = wr_en && (PADDR_IN == `OFS_CTRL) && PWDATA_IN[`CTRL_START];
  // entry fires once, the first time software reports driver init done
  assign auto_start  = init_done_reg && !auto_done_reg && !busy;
  // a zero limit behaves as one interval of busy time
  assign eff_limit   = (limit_reg == 32'h0) ? 32'h1 : limit_reg;
  assign half_period = (div_reg < `MIN_SCLK_DIV) ? `MIN_SCLK_DIV : div_reg;
  assign IRQ_OUT     = |(irq_stat_reg & irq_en_reg);

  // ************************************************************
  // miso synchroniser
  // ************************************************************
  always @(posedge CLK_SYS_IN) begin
    if (SYS_RST_IN) begin
      miso_s1_reg <= 1'b0;
      miso_s2_reg <= 1'b0;
    end else begin
      miso_s1_reg <= SPI_MISO_IN;
      miso_s2_reg <= miso_s1_reg;
    end
  end

  spi_byte_shifter shifter (
    .clk         (CLK_SYS_IN),
    .rst         (SYS_RST_IN),
    .half_period (half_period),
    .start       (eng_start),
    .tx_byte     (eng_tx),
    .miso_sync   (miso_s2_reg),
    .sclk_out    (SPI_SCLK_OUT),
    .mosi_out    (SPI_MOSI_OUT),
    .rx_byte     (eng_rx),
    .done        (eng_done)
  );

  // ************************************************************
  // apb registers
  // ************************************************************
  // writes to interval and limit while busy are ignored so a running
  // wait keeps the per-class values it was started with
  always @(posedge CLK_SYS_IN) begin
    if (SYS_RST_IN) begin
      interval_reg  <= `RST_INTERVAL;
      limit_reg     <= `RST_LIMIT;
      div_reg       <= `RST_SCLK_DIV;
      irq_en_reg    <= 2'h0;
      init_done_reg <= 1'b0;
    end else if (wr_en) begin
      if (PADDR_IN == `OFS_CTRL) begin
        if (PWDATA_IN[`CTRL_INIT_DONE])
          init_done_reg <= 1'b1;
      end else if (PADDR_IN == `OFS_INTERVAL && !busy) begin
        interval_reg <= PWDATA_IN;
      end else if (PADDR_IN == `OFS_LIMIT && !busy) begin
        limit_reg <= PWDATA_IN;
      end else if (PADDR_IN == `OFS_IRQ_EN) begin
        irq_en_reg <= PWDATA_IN[1:0];
      end else if (PADDR_IN == `OFS_SCLK_DIV && !busy) begin
        div_reg <= PWDATA_IN[7:0];
      end
    end
  end

  always @(posedge CLK_SYS_IN) begin
    if (SYS_RST_IN) begin
      PRDATA_OUT <= 32'h0;
    end else if (rd_en && !PENABLE_IN) begin
      if (PADDR_IN == `OFS_CTRL)
        PRDATA_OUT <= {28'h0, init_done_reg, mode_reg, kind_reg[1], busy};
      else if (PADDR_IN == `OFS_STATUS)
        PRDATA_OUT <= {sec_byte_reg, status_byte_reg, 7'h0, wide_ok_reg,
                       1'b0, result_reg, 3'h0, busy};
      else if (PADDR_IN == `OFS_INTERVAL)
        PRDATA_OUT <= interval_reg;
      else if (PADDR_IN == `OFS_LIMIT)
        PRDATA_OUT <= limit_reg;
      else if (PADDR_IN == `OFS_IRQ_STAT)
        PRDATA_OUT <= {30'h0, irq_stat_reg};
      else if (PADDR_IN == `OFS_IRQ_EN)
        PRDATA_OUT <= {30'h0, irq_en_reg};
      else if (PADDR_IN == `OFS_SCLK_DIV)
        PRDATA_OUT <= {24'h0, div_reg};
      else
        PRDATA_OUT <= 32'h0;
    end
  end

  // ************************************************************
  // interrupt status: set wins over clear
  // ************************************************************
  always @(posedge CLK_SYS_IN) begin
    if (SYS_RST_IN) begin
      irq_stat_reg <= 2'h0;
    end else begin
      if (wr_en && PADDR_IN == `OFS_IRQ_CLR)
        irq_stat_reg <= irq_stat_reg & ~PWDATA_IN[1:0] |
                        {finish && finish_res != `RES_SUCCESS, finish};
      else
        irq_stat_reg <= irq_stat_reg | {finish && finish_res != `RES_SUCCESS, finish};
    end
  end

  // ************************************************************
  // sequencer
  // ************************************************************
  always @* begin
    eng_start  = 1'b0;
    eng_tx     = 8'h00;
    finish     = 1'b0;
    finish_res = `RES_SUCCESS;
    if (state_reg == S_CSLO) begin
      eng_start = 1'b1;
      if (kind_reg == K_STATUS)
        eng_tx = READ_STATUS_CMD;
      else if (kind_reg == K_SECURITY)
        eng_tx = READ_SECURITY_CMD;
      else if (kind_reg == K_ENTER)
        eng_tx = ENTER_WIDE_CMD;
      else
        eng_tx = READ_CONFIG_CMD;
    end else if (state_reg == S_CMD && eng_done && kind_reg != K_ENTER) begin
      eng_start = 1'b1;
    end else if (state_reg == S_IDLE && !auto_start && sw_start) begin
      // a zero interval could never space the polls apart
      if (!PWDATA_IN[`CTRL_OP] && interval_reg == 32'h0) begin
        finish     = 1'b1;
        finish_res = `RES_PARAM_ERR;
      end
    end else if (state_reg == S_CSHI) begin
      if (kind_reg == K_STATUS && status_byte_reg[BUSY_BIT] &&
          poll_cnt_reg >= eff_limit) begin
        finish     = 1'b1;
        finish_res = `RES_TIMEOUT;
      end else if (kind_reg == K_STATUS && !status_byte_reg[BUSY_BIT] && !mode_reg) begin
        finish = 1'b1;
      end else if (kind_reg == K_SECURITY) begin
        finish     = 1'b1;
        finish_res = (sec_byte_reg[ERASE_FAIL_BIT] || sec_byte_reg[PROG_FAIL_BIT]) ?
                     `RES_HARD_ERR : `RES_SUCCESS;
      end else if (kind_reg == K_CONFIG) begin
        finish     = 1'b1;
        finish_res = status_byte_reg[WIDE_ADDR_BIT] ? `RES_SUCCESS : `RES_HARD_ERR;
      end
    end
  end

  always @(posedge CLK_SYS_IN) begin
    if (SYS_RST_IN) begin
      state_reg       <= S_IDLE;
      kind_reg        <= K_STATUS;
      mode_reg        <= 1'b0;
      SPI_CS_N_OUT    <= 1'b1;
      wait_cnt_reg    <= 32'h0;
      poll_cnt_reg    <= 32'h0;
      result_reg      <= `RES_SUCCESS;
      wide_ok_reg     <= 1'b0;
      status_byte_reg <= 8'h00;
      sec_byte_reg    <= 8'h00;
      auto_done_reg   <= 1'b0;
    end else begin
      if (finish)
        result_reg <= finish_res;
      case (state_reg)
        S_IDLE: begin
          poll_cnt_reg <= 32'h0;
          if (auto_start) begin
            auto_done_reg <= 1'b1;
            kind_reg      <= K_ENTER;
            state_reg     <= S_CSLO;
          end else if (sw_start && !finish) begin
            // standalone wait, or a wide-address entry on request
            mode_reg  <= PWDATA_IN[`CTRL_MODE];
            kind_reg  <= PWDATA_IN[`CTRL_OP] ? K_ENTER : K_STATUS;
            state_reg <= S_CSLO;
          end
        end
        S_CSLO: begin
          SPI_CS_N_OUT <= 1'b0;
          state_reg    <= S_CMD;
        end
        S_CMD: begin
          if (eng_done)
            state_reg <= (kind_reg == K_ENTER) ? S_CSHI : S_DATA;
        end
        S_DATA: begin
          if (eng_done) begin
            if (kind_reg == K_SECURITY)
              sec_byte_reg <= eng_rx;
            else
              status_byte_reg <= eng_rx;
            state_reg <= S_CSHI;
          end
        end
        S_CSHI: begin
          SPI_CS_N_OUT <= 1'b1;
          if (kind_reg == K_CONFIG)
            wide_ok_reg <= status_byte_reg[WIDE_ADDR_BIT];
          if (finish) begin
            state_reg <= S_IDLE;
          end else if (kind_reg == K_ENTER) begin
            kind_reg  <= K_CONFIG;
            state_reg <= S_WAIT;
            wait_cnt_reg <= {24'h0, half_period};
          end else if (status_byte_reg[BUSY_BIT]) begin
            wait_cnt_reg <= interval_reg;
            state_reg    <= S_WAIT;
          end else begin
            kind_reg     <= K_SECURITY;
            wait_cnt_reg <= {24'h0, half_period};
            state_reg    <= S_WAIT;
          end
        end
        S_WAIT: begin
          if (wait_cnt_reg <= 32'h1) begin
            if (kind_reg == K_STATUS)
              poll_cnt_reg <= poll_cnt_reg + 32'h1;
            state_reg <= S_CSLO;
          end else begin
            wait_cnt_reg <= wait_cnt_reg - 32'h1;
          end
        end
        default: begin
          state_reg <= S_IDLE;
        end
      endcase
    end
  end

endmodule

// >>> rtl/flash_poll_defs.vh
// register offsets, field positions, reset values and result codes
// of the busy-poll sequencer; included by the sequencer, its assertions and its bench
`ifndef FLASH_POLL_DEFS_VH
`define FLASH_POLL_DEFS_VH

// ************************************************************
// register offsets (byte addresses, one word each)
// ************************************************************
`define OFS_CTRL       12'h000
`define OFS_STATUS     12'h004
`define OFS_INTERVAL   12'h008
`define OFS_LIMIT      12'h00C
`define OFS_IRQ_STAT   12'h010
`define OFS_IRQ_CLR    12'h014
`define OFS_IRQ_EN     12'h018
`define OFS_SCLK_DIV   12'h01C

// ************************************************************
// field positions
// ************************************************************
`define CTRL_START     0
`define CTRL_OP        1
`define CTRL_MODE      2
`define CTRL_INIT_DONE 3
`define ST_BUSY        0
`define ST_RES_LO      4
`define ST_RES_HI      6
`define ST_WIDE_OK     8
`define ST_SR_LO       16
`define ST_SR_HI       23
`define ST_SEC_LO      24
`define ST_SEC_HI      31
`define IRQ_DONE       0
`define IRQ_ERR        1

// ************************************************************
// reset values
// ************************************************************
`define RST_INTERVAL   32'h0000_0400
`define RST_LIMIT      32'h0000_0010
`define RST_SCLK_DIV   8'h04
`define MIN_SCLK_DIV   8'h04

// ************************************************************
// result codes
// ************************************************************
`define RES_SUCCESS    3'h0
`define RES_PARAM_ERR  3'h1
`define RES_HARD_ERR   3'h2
`define RES_TIMEOUT    3'h3
`define RES_OTHER_ERR  3'h4

`endif

// >>> rtl/spi_byte_shifter.v
// one-byte spi mode 0 shifter, msb first, sclk made by a divider
// assumes miso already passed two flip-flops; chip select is the caller's
`timescale 1ns/10ps
module spi_byte_shifter (
  input  wire       clk,
  input  wire       rst,
  input  wire [7:0] half_period,
  input  wire       start,
  input  wire [7:0] tx_byte,
  input  wire       miso_sync,
  output reg        sclk_out,
  output reg        mosi_out,
  output reg  [7:0] rx_byte,
  output reg        done
);

  reg        active_reg;
  reg  [7:0] div_reg;
  reg  [2:0] bit_reg;
  reg  [7:0] tx_reg;

  // ************************************************************
  // shift engine
  // ************************************************************
  // miso is taken at the falling edge: the two-stage sync needs a
  // half period of at least four clocks, the caller enforces it
  always @(posedge clk) begin
    done <= 1'b0;
    if (rst) begin
      active_reg <= 1'b0;
      div_reg    <= 8'h00;
      bit_reg    <= 3'h0;
      tx_reg     <= 8'h00;
      sclk_out   <= 1'b0;
      mosi_out   <= 1'b0;
      rx_byte    <= 8'h00;
    end else if (!active_reg) begin
      sclk_out <= 1'b0;
      if (start) begin
        active_reg <= 1'b1;
        tx_reg     <= {tx_byte[6:0], 1'b0};
        mosi_out   <= tx_byte[7];
        bit_reg    <= 3'h0;
        div_reg    <= 8'h01;
      end
    end else if (div_reg >= half_period) begin
      div_reg  <= 8'h01;
      sclk_out <= ~sclk_out;
      if (sclk_out) begin
        rx_byte <= {rx_byte[6:0], miso_sync};
        bit_reg <= bit_reg + 3'h1;
        if (bit_reg == 3'h7) begin
          active_reg <= 1'b0;
          done       <= 1'b1;
        end else begin
          mosi_out <= tx_reg[7];
          tx_reg   <= {tx_reg[6:0], 1'b0};
        end
      end
    end else begin
      div_reg <= div_reg + 8'h01;
    end
  end

endmodule

// >>> sim/flash_poll_checker_assertions.sv
// assertions on the busy-poll sequencer's apb and spi pins
// assumes it is bound into flash_busy_poll_ctrl and sees its ports only
`timescale 1ns/10ps
`include "flash_poll_defs.vh"
module flash_poll_checker (
  input wire        CLK_SYS_IN,
  input wire        SYS_RST_IN,
  input wire        PSEL_IN,
  input wire        PENABLE_IN,
  input wire        PWRITE_IN,
  input wire [11:0] PADDR_IN,
  input wire [31:0] PWDATA_IN,
  input wire        PREADY_OUT,
  input wire [31:0] PRDATA_OUT,
  input wire        PSLVERR_OUT,
  input wire        IRQ_OUT,
  input wire        SPI_SCLK_OUT,
  input wire        SPI_CS_N_OUT,
  input wire        SPI_MOSI_OUT,
  input wire        SPI_MISO_IN
);
  // ********
  // frame monitor, counts sclk rises per frame
  // ********
  logic [4:0] rises;
  logic [7:0] cmd_seen;
  logic       sclk_q;
  default clocking @(posedge CLK_SYS_IN);
  endclocking
  default disable iff (SYS_RST_IN);
  always @(posedge CLK_SYS_IN) begin
    sclk_q <= SPI_SCLK_OUT;
    if (SYS_RST_IN || SPI_CS_N_OUT) begin
      rises    <= 5'h00;
      cmd_seen <= 8'h00;
    end else if (SPI_SCLK_OUT && !sclk_q) begin
      rises    <= rises + 5'h01;
      cmd_seen <= (rises < 5'h08) ? {cmd_seen[6:0], SPI_MOSI_OUT} : cmd_seen;
    end
  end
  sequence s_lead_in;
    !SPI_SCLK_OUT [*3];
  endsequence
  sequence s_gap;
    SPI_CS_N_OUT [*3];
  endsequence
  sequence s_status_read;
    PSEL_IN && PENABLE_IN && !PWRITE_IN && PADDR_IN == `OFS_STATUS;
  endsequence
  a_sclk_idle_low: assert property (SPI_CS_N_OUT |-> !SPI_SCLK_OUT)
    else $error("sclk moved outside a frame");
  a_frame_lead_in: assert property ($fell(SPI_CS_N_OUT) |-> s_lead_in)
    else $error("sclk rose too soon after select");
  a_frame_gap: assert property ($rose(SPI_CS_N_OUT) |-> s_gap)
    else $error("select gap too short");
  a_frame_bits: assert property ($rose(SPI_CS_N_OUT) |-> rises == 5'h08 || rises == 5'h10)
    else $error("frame not 8 or 16 bits");
  a_mosi_steady: assert property (SPI_SCLK_OUT && sclk_q |-> $stable(SPI_MOSI_OUT))
    else $error("mosi moved while sclk high");
  a_cmd_known: assert property (rises == 5'h08 |->
    cmd_seen inside {8'h05, 8'h2B, 8'hB7, 8'h15})
    else $error("unknown command byte");
  a_entry_alone: assert property ($rose(SPI_CS_N_OUT) && rises == 5'h08 |->
    cmd_seen == 8'hB7)
    else $error("short frame is not the entry command");
  a_result_legal: assert property (s_status_read |-> PRDATA_OUT[6:4] <= `RES_TIMEOUT)
    else $error("result code out of range");
  a_unmapped_err: assert property (PSEL_IN && PENABLE_IN && PADDR_IN > `OFS_SCLK_DIV
    |-> PSLVERR_OUT && (PWRITE_IN || PRDATA_OUT == 32'h0))
    else $error("unmapped access not refused");
endmodule
bind flash_busy_poll_ctrl flash_poll_checker i_flash_poll_checker (
  .CLK_SYS_IN(CLK_SYS_IN), .SYS_RST_IN(SYS_RST_IN), .PSEL_IN(PSEL_IN),
  .PENABLE_IN(PENABLE_IN), .PWRITE_IN(PWRITE_IN), .PADDR_IN(PADDR_IN),
  .PWDATA_IN(PWDATA_IN), .PREADY_OUT(PREADY_OUT), .PRDATA_OUT(PRDATA_OUT),
  .PSLVERR_OUT(PSLVERR_OUT), .IRQ_OUT(IRQ_OUT), .SPI_SCLK_OUT(SPI_SCLK_OUT),
  .SPI_CS_N_OUT(SPI_CS_N_OUT), .SPI_MOSI_OUT(SPI_MOSI_OUT), .SPI_MISO_IN(SPI_MISO_IN));

// >>> sim/flash_model.sv
// behavioural serial flash answering status, security and config reads
// assumes spi mode 0, msb first; the bench clears the counters with arm
`timescale 1ns/10ps
module flash_model (
  input  wire       sclk,
  input  wire       cs_n,
  input  wire       mosi,
  input  wire       arm,
  input  int        busy,
  input  wire [6:0] noise,
  input  wire       pfail,
  input  wire       efail,
  input  wire       refuse,
  output logic      miso,
  output int        n_status,
  output int        n_sec,
  output int        n_entry
);
  logic [7:0] cmd;
  logic [7:0] tx;
  logic       wide;
  int         bits;
  initial begin
    miso = 1'b0;
    wide = 1'b0;
    bits = 0;
  end
  always @(posedge arm) begin
    n_status = 0;
    n_sec = 0;
    n_entry = 0;
  end
  always @(negedge cs_n) bits = 0;
  always @(posedge sclk) if (!cs_n) begin
    if (bits < 8) cmd = {cmd[6:0], mosi};
    bits = bits + 1;
  end
  // noise fills the other status bits so only the busy bit may matter
  always @(negedge sclk) if (!cs_n) begin
    if (bits == 8) begin
      case (cmd)
        8'h05:   tx = {noise, n_status < busy};
        8'h2B:   tx = {1'b0, efail, pfail, 5'h00};
        8'h15:   tx = {2'b00, wide & ~refuse, 5'h00};
        default: tx = 8'h00;
      endcase
      n_status += (cmd == 8'h05);
      n_sec += (cmd == 8'h2B);
    end else tx = {tx[6:0], 1'b0};
    miso = tx[7];
  end
  // released line shows the inverse, never a stale level
  always @(posedge cs_n) begin
    if (bits == 8 && cmd == 8'hB7) begin
      wide = 1'b1;
      n_entry = n_entry + 1;
    end
    miso = ~miso;
  end
endmodule

// >>> sim/flash_busy_poll_ctrl_test.sv
// bench for the busy-poll sequencer with a behavioural flash on its pins
// assumes flash_model and the rtl include path are available
`timescale 1ns/10ps
`include "flash_poll_defs.vh"
module flash_busy_poll_ctrl_test;
  logic        clk, rst, psel, pen, pwr, arm, pf, ef, refuse, e;
  logic [11:0] paddr;
  logic [31:0] pwdata, rd, r;
  logic [6:0]  noise;
  logic [2:0]  res;
  logic [1:0]  en;
  wire         pready, pslverr, irq, sclk, cs_n, mosi, miso;
  wire  [31:0] prdata;
  int          n_fail, checks_done, seed, busy, n_st, n_sec, n_ent, lim, md, k;
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  flash_busy_poll_ctrl i_flash_busy_poll_ctrl (.CLK_SYS_IN(clk), .SYS_RST_IN(rst),
    .PSEL_IN(psel), .PENABLE_IN(pen), .PWRITE_IN(pwr), .PADDR_IN(paddr), .PWDATA_IN(pwdata),
    .PREADY_OUT(pready), .PRDATA_OUT(prdata), .PSLVERR_OUT(pslverr), .IRQ_OUT(irq),
    .SPI_SCLK_OUT(sclk), .SPI_CS_N_OUT(cs_n), .SPI_MOSI_OUT(mosi), .SPI_MISO_IN(miso));
  flash_model i_flash_model (.sclk(sclk), .cs_n(cs_n), .mosi(mosi), .arm(arm), .busy(busy),
    .noise(noise), .pfail(pf), .efail(ef), .refuse(refuse), .miso(miso), .n_status(n_st),
    .n_sec(n_sec), .n_entry(n_ent));
  task check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_fail++;
      $display("unexpected %s: expected %h seen %h", name, exp, seen);
    end
  endtask
  task stop_test;
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int i;
    @(posedge clk);
    psel   <= 1'b1;
    pwr    <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    i = 0;
    do begin
      @(posedge clk);
      i++;
    end while (pready !== 1'b1 && i < 8);
    if (pready !== 1'b1) begin
      n_fail++;
      stop_test;
    end
    rd = prdata;
    e = pslverr;
    psel <= 1'b0;
    pen  <= 1'b0;
  endtask
  // waits for the first frame so a late start is not read as done
  task wait_done(input logic spi);
    int i;
    for (i = 0; spi && i < 200 && cs_n !== 1'b0; i++) @(posedge clk);
    if (spi && cs_n !== 1'b0) begin
      n_fail++;
      stop_test;
    end
    for (i = 0; i < 1000; i++) begin
      apb(1'b0, `OFS_STATUS, 32'h0);
      if (rd[0] === 1'b0) break;
    end
    if (i == 1000) begin
      n_fail++;
      stop_test;
    end
  endtask
  task arm_model;
    arm <= 1'b1;
    @(posedge clk);
    arm <= 1'b0;
  endtask
  function automatic int exp_polls(int l, int b);
    int eff;
    eff = (l == 0) ? 1 : l;
    return (b > eff) ? eff + 1 : b + 1;
  endfunction
  function automatic logic [2:0] exp_res(int m, int l, int b, logic f);
    if (b > ((l == 0) ? 1 : l)) return `RES_TIMEOUT;
    return (m == 1 && f) ? `RES_HARD_ERR : `RES_SUCCESS;
  endfunction
  initial begin
    seed = 20025;
    n_fail = 0;
    checks_done = 0;
    rst = 1'b1;
    {psel, pen, pwr, arm, pf, ef, refuse} = 7'h00;
    paddr = 12'h000;
    pwdata = 32'h0;
    noise = 7'h00;
    busy = 0;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    apb(1'b0, `OFS_INTERVAL, 32'h0);
    check("interval reset", rd, `RST_INTERVAL);
    apb(1'b0, `OFS_LIMIT, 32'h0);
    check("limit reset", rd, `RST_LIMIT);
    apb(1'b0, `OFS_SCLK_DIV, 32'h0);
    check("sclk div reset", rd, 32'(`RST_SCLK_DIV));
    apb(1'b0, 12'h020, 32'h0);
    check("unmapped read", {rd[30:0], e}, 32'h1);
    arm_model;
    apb(1'b1, `OFS_CTRL, 32'h8);
    wait_done(1'b1);
    check("auto entry", 32'({rd[8], rd[6:4], n_ent[3:0]}), 32'h81);
    apb(1'b1, `OFS_CTRL, 32'h8);
    apb(1'b0, `OFS_STATUS, 32'h0);
    check("entry once", 32'(rd[0]), 32'h0);
    apb(1'b0, `OFS_CTRL, 32'h0);
    check("ctrl after entry", rd, 32'hA);
    apb(1'b1, `OFS_INTERVAL, 32'h14);
    // first two runs are the zero-limit corner: one busy poll, then two
    for (k = 0; k < 14; k++) begin
      r = $random(seed);
      md = k % 2;
      lim = (k < 2) ? 0 : int'(r[4:3]);
      busy = (k < 2) ? k + 1 : int'(r[7:5]);
      {noise, pf, ef, en} = r[20:10];
      arm_model;
      apb(1'b1, `OFS_LIMIT, 32'(lim));
      apb(1'b1, `OFS_IRQ_EN, 32'(en));
      apb(1'b1, `OFS_CTRL, 32'(md * 4 + 1));
      apb(1'b1, `OFS_INTERVAL, 32'h7);
      wait_done(1'b1);
      res = exp_res(md, lim, busy, pf | ef);
      check("result", 32'(rd[6:4]), 32'(res));
      check("status byte", 32'(rd[23:16]), 32'({noise, res == `RES_TIMEOUT}));
      if (md == 1 && res != `RES_TIMEOUT)
        check("security byte", 32'(rd[31:24]), 32'({1'b0, ef, pf, 5'h00}));
      check("status polls", 32'(n_st), 32'(exp_polls(lim, busy)));
      check("security reads", 32'(n_sec), 32'(md == 1 && res != `RES_TIMEOUT));
      apb(1'b0, `OFS_CTRL, 32'h0);
      check("ctrl mode", rd, 32'(8 + md * 4));
      apb(1'b0, `OFS_INTERVAL, 32'h0);
      check("interval kept", rd, 32'h14);
      apb(1'b0, `OFS_IRQ_STAT, 32'h0);
      check("irq state", rd, {30'h0, res != 3'h0, 1'b1});
      check("irq level", 32'(irq), 32'(|({res != 3'h0, 1'b1} & en)));
      apb(1'b1, `OFS_IRQ_CLR, 32'h3);
      apb(1'b0, `OFS_IRQ_STAT, 32'h0);
      check("irq cleared", {rd[30:0], irq}, 32'h0);
    end
    arm_model;
    apb(1'b1, `OFS_INTERVAL, 32'h0);
    apb(1'b1, `OFS_CTRL, 32'h1);
    wait_done(1'b0);
    check("zero interval", 32'({rd[6:4], n_st[3:0]}), 32'h10);
    apb(1'b1, `OFS_INTERVAL, 32'h14);
    for (k = 0; k < 2; k++) begin
      refuse = (k == 0);
      arm_model;
      apb(1'b1, `OFS_CTRL, 32'h3);
      wait_done(1'b1);
      check("entry result", 32'({rd[6:4], n_ent[3:0]}), refuse ? 32'h21 : 32'h01);
    end
    stop_test;
  end
endmodule
